/* File: hw/ddc_ctrl.sv */
// DDR controller front end: two AXI-style ports, address mapping, power management
`timescale 1ns/1ps

// Overview of operation
// - Each accepted address is split into bank, row and column by the selected ordering.
// - With active or precharge power-down chosen, idle time puts memory into that power-down.
// - With self-refresh enabled, a longer idle time puts memory into self-refresh.
// - Gate override replaces calibrated delays with user coarse 0-5 and fine 0-255 values.
// - In disable-control mode the calibration and user reset pins are ignored.
// - With calibration on, master reset and the SCL/SDA pair are honoured.
// - With user reset on, master reset and sequencer start are honoured.
// - Two ports, 0 and 1, each separately enabled; a disabled port accepts nothing.
// - Each port is paced by its own clock input, optionally inverted.
// - Each port has a shared address channel plus write data, write response and read data.
// - Every memory access is a burst of eight.
module ddc_ctrl #(
	parameter int PD_IDLE = ddc_pkg::PD_IDLE_CYC,
	parameter int SR_IDLE = ddc_pkg::SR_IDLE_CYC
) (
	// Clock and reset
	input  wire logic                                          sys_clk,
	input  wire logic                                          nrst,
	// Configuration
	input  wire ddc_pkg::ddc_map_type                          map_mode,
	input  wire ddc_pkg::ddc_apd_type                          apd_mode,
	input  wire logic                                          sr_en,
	input  wire ddc_pkg::ddc_ctl_type                          ctl_mode,
	input  wire logic                                          gate_ovr_en,
	input  wire logic [ddc_pkg::COARSE_W-1:0]                  gate_ovr_coarse,
	input  wire logic [ddc_pkg::FINE_W-1:0]                    gate_ovr_fine,
	// Control pins from fabric
	input  wire logic                                          master_rst_n,
	input  wire logic                                          seq_start,
	input  wire logic                                          cal_scl,
	input  wire logic                                          cal_sda,
	// AXI ports
	input  wire logic [ddc_pkg::NPORT-1:0]                     port_en,
	input  wire logic [ddc_pkg::NPORT-1:0]                     axi_clk,
	input  wire logic [ddc_pkg::NPORT-1:0]                     axi_clk_inv,
	input  wire ddc_pkg::ddc_axi_in_type [ddc_pkg::NPORT-1:0]  axi_in,
	output ddc_pkg::ddc_axi_out_type [ddc_pkg::NPORT-1:0]      axi_out,
	// Memory command side
	input  wire ddc_pkg::ddc_mem_in_type                       mem_in,
	output ddc_pkg::ddc_mem_out_type                           mem_out,
	output logic [ddc_pkg::COARSE_W-1:0]                       gate_coarse,
	output logic [ddc_pkg::FINE_W-1:0]                         gate_fine,
	// Status
	output logic                                               init_done,
	output logic                                               in_pd,
	output logic                                               in_sr
);
	localparam int CW = ddc_pkg::COL_W;
	localparam int RW = ddc_pkg::ROW_W;
	localparam int BW = ddc_pkg::BANK_W;
	localparam int LW = ddc_pkg::COLL_W;
	localparam int DW = ddc_pkg::DATA_W;
	localparam int NP = ddc_pkg::NPORT;
	localparam int WORD_W = CW + RW + BW;
	localparam logic [ddc_pkg::BEAT_W-1:0] LAST_BEAT = ddc_pkg::BEAT_W'(ddc_pkg::BURST_LEN - 1);
	localparam logic [ddc_pkg::IDLE_W-1:0] PD_LIM = ddc_pkg::IDLE_W'(PD_IDLE - 1);
	localparam logic [ddc_pkg::IDLE_W-1:0] SR_LIM = ddc_pkg::IDLE_W'(SR_IDLE - 1);
	localparam logic [ddc_pkg::CALCNT_W-1:0] CAL_LAST = ddc_pkg::CALCNT_W'(ddc_pkg::CAL_BITS - 1);

	typedef enum logic [3:0] {ST_INIT_WAIT, ST_INIT_PRE, ST_IDLE, ST_PD, ST_SRE, ST_SR,
		ST_WAKE, ST_WCOL, ST_ACT, ST_CMD, ST_WBEAT, ST_RBEAT, ST_PRE, ST_RSEND,
		ST_RESP} ddc_st_type;

	typedef struct packed {
		ddc_st_type                                   st;
		logic                                         port;
		logic                                         rr;
		logic                                         write;
		logic [BW-1:0]                                bank;
		logic [RW-1:0]                                row;
		logic [CW-1:0]                                col;
		logic [ddc_pkg::BEAT_W-1:0]                   beat;
		logic [ddc_pkg::IDLE_W-1:0]                   idle_cnt;
		logic [ddc_pkg::WAKE_W-1:0]                   wake_cnt;
		logic [ddc_pkg::BURST_LEN-1:0][DW-1:0]        data_buf;
		logic [NP-1:0]                                clk_prev;
		logic                                         scl_prev;
		logic [ddc_pkg::CAL_BITS-1:0]                 cal_shift;
		logic [ddc_pkg::CALCNT_W-1:0]                 cal_cnt;
		logic [ddc_pkg::COARSE_W-1:0]                 cal_coarse;
		logic [ddc_pkg::FINE_W-1:0]                   cal_fine;
		logic [ddc_pkg::COARSE_W-1:0]                 gate_coarse;
		logic [ddc_pkg::FINE_W-1:0]                   gate_fine;
		logic                                         init_done;
		logic                                         in_pd;
		logic                                         in_sr;
		ddc_pkg::ddc_axi_out_type [NP-1:0]            axo;
		ddc_pkg::ddc_mem_out_type                     mem;
	} ddc_state_type;

	ddc_state_type q_q;
	ddc_state_type d_d;

	// ----------------------------------------
	// Per-port clock pacing
	// ----------------------------------------
	logic [NP-1:0] eff_clk;
	logic [NP-1:0] port_edge;
	for (genvar gi = 0; gi < NP; gi++) begin : g_port
		assign eff_clk[gi]   = axi_clk[gi] ^ axi_clk_inv[gi];
		assign port_edge[gi] = eff_clk[gi] & ~q_q.clk_prev[gi];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [WORD_W-1:0]               word;
		logic                            idle_like;
		logic                            take;
		logic                            cal_en;
		logic                            usr_en;
		logic [ddc_pkg::COARSE_W-1:0]    coarse;
		word      = axi_in[q_q.rr].a_addr[ddc_pkg::BYTE_LSB +: WORD_W];
		cal_en    = (ctl_mode == ddc_pkg::CTL_CAL) || (ctl_mode == ddc_pkg::CTL_BOTH);
		usr_en    = (ctl_mode == ddc_pkg::CTL_USER) || (ctl_mode == ddc_pkg::CTL_BOTH);
		idle_like = (q_q.st == ST_IDLE) || (q_q.st == ST_PD) || (q_q.st == ST_SR);
		take      = idle_like && port_edge[q_q.rr] && q_q.axo[q_q.rr].a_ready
			&& axi_in[q_q.rr].a_valid;
		coarse    = gate_ovr_en ? gate_ovr_coarse : q_q.cal_coarse;
		d_d = q_q;
		d_d.clk_prev   = eff_clk;
		d_d.scl_prev   = cal_scl;
		d_d.mem.cmd    = ddc_pkg::CMD_NOP;
		d_d.mem.wvalid = 1'b0;

		// Serial load of calibrated gate delays, coarse then fine, MSB first
		if (cal_en && cal_scl && !q_q.scl_prev) begin
			d_d.cal_shift = {q_q.cal_shift[ddc_pkg::CAL_BITS-2:0], cal_sda};
			d_d.cal_cnt   = q_q.cal_cnt + 1'b1;
			if (q_q.cal_cnt == CAL_LAST) begin
				d_d.cal_cnt    = '0;
				d_d.cal_fine   = d_d.cal_shift[ddc_pkg::FINE_W-1:0];
				d_d.cal_coarse = d_d.cal_shift[ddc_pkg::CAL_BITS-1 -: ddc_pkg::COARSE_W];
			end
		end
		// Out-of-range coarse values saturate rather than wrap
		d_d.gate_coarse = (coarse > ddc_pkg::COARSE_MAX) ? ddc_pkg::COARSE_MAX : coarse;
		d_d.gate_fine   = gate_ovr_en ? gate_ovr_fine : q_q.cal_fine;

		case (q_q.st)
			ST_INIT_WAIT: begin
				if (!usr_en || seq_start) begin
					d_d.st = ST_INIT_PRE;
				end
			end
			ST_INIT_PRE: begin
				d_d.mem.cmd   = ddc_pkg::CMD_PREA;
				d_d.init_done = 1'b1;
				d_d.idle_cnt  = '0;
				d_d.st        = ST_IDLE;
			end
			ST_IDLE, ST_PD, ST_SR: begin
				if (take) begin
					d_d.port     = q_q.rr;
					d_d.write    = axi_in[q_q.rr].a_write;
					d_d.idle_cnt = '0;
					d_d.beat     = '0;
					case (map_mode)
						ddc_pkg::MAP_ROW_BANK_COL: begin
							d_d.col  = word[0 +: CW];
							d_d.bank = word[CW +: BW];
							d_d.row  = word[CW + BW +: RW];
						end
						ddc_pkg::MAP_ROW_COLH_BANK_COLL: begin
							d_d.col  = {word[LW + BW +: CW - LW], word[0 +: LW]};
							d_d.bank = word[LW +: BW];
							d_d.row  = word[CW + BW +: RW];
						end
						default: begin
							d_d.col  = word[0 +: CW];
							d_d.row  = word[CW +: RW];
							d_d.bank = word[CW + RW +: BW];
						end
					endcase
					if (q_q.st != ST_IDLE) begin
						d_d.mem.cmd  = (q_q.st == ST_SR) ? ddc_pkg::CMD_SRX : ddc_pkg::CMD_PDX;
						d_d.wake_cnt = ddc_pkg::WAKE_W'(ddc_pkg::WAKE_CYC);
						d_d.in_pd    = 1'b0;
						d_d.in_sr    = 1'b0;
						d_d.st       = ST_WAKE;
					end else begin
						d_d.st = axi_in[q_q.rr].a_write ? ST_WCOL : ST_ACT;
					end
				end else begin
					if (q_q.st != ST_SR && q_q.idle_cnt != '1) begin
						d_d.idle_cnt = q_q.idle_cnt + 1'b1;
					end
					if (port_edge[q_q.rr] || !port_en[q_q.rr]) begin
						d_d.rr = port_en[!q_q.rr] ? !q_q.rr : q_q.rr;
					end
					if (q_q.st == ST_IDLE && apd_mode != ddc_pkg::APD_OFF
						&& q_q.idle_cnt >= PD_LIM) begin
						d_d.mem.cmd = (apd_mode == ddc_pkg::APD_ACTIVE) ?
							ddc_pkg::CMD_PDE_ACT : ddc_pkg::CMD_PDE_PRE;
						d_d.in_pd = 1'b1;
						d_d.st    = ST_PD;
					end else if (q_q.st != ST_SR && sr_en && q_q.idle_cnt >= SR_LIM) begin
						// Power-down must be left before self-refresh is entered
						if (q_q.st == ST_PD) begin
							d_d.mem.cmd = ddc_pkg::CMD_PDX;
						end
						d_d.in_pd = 1'b0;
						d_d.st    = ST_SRE;
					end
				end
			end
			ST_SRE: begin
				d_d.mem.cmd = ddc_pkg::CMD_SRE;
				d_d.in_sr   = 1'b1;
				d_d.st      = ST_SR;
			end
			ST_WAKE: begin
				d_d.wake_cnt = q_q.wake_cnt - 1'b1;
				if (q_q.wake_cnt <= 1) begin
					d_d.st = q_q.write ? ST_WCOL : ST_ACT;
				end
			end
			ST_WCOL: begin
				if (port_edge[q_q.port] && q_q.axo[q_q.port].w_ready
					&& axi_in[q_q.port].w_valid) begin
					d_d.data_buf[q_q.beat] = axi_in[q_q.port].w_data;
					d_d.beat = q_q.beat + 1'b1;
					if (q_q.beat == LAST_BEAT) begin
						d_d.st = ST_ACT;
					end
				end
			end
			ST_ACT: begin
				d_d.mem.cmd  = ddc_pkg::CMD_ACT;
				d_d.mem.bank = q_q.bank;
				d_d.mem.row  = q_q.row;
				d_d.st       = ST_CMD;
			end
			ST_CMD: begin
				// Burst-aligned column: the low LW bits are sent as zero
				d_d.mem.cmd = q_q.write ? ddc_pkg::CMD_WR : ddc_pkg::CMD_RD;
				d_d.mem.col = {q_q.col[CW-1:LW], {LW{1'b0}}};
				d_d.beat    = '0;
				d_d.st      = q_q.write ? ST_WBEAT : ST_RBEAT;
			end
			ST_WBEAT: begin
				d_d.mem.wvalid = 1'b1;
				d_d.mem.wdata  = q_q.data_buf[q_q.beat];
				d_d.beat       = q_q.beat + 1'b1;
				if (q_q.beat == LAST_BEAT) begin
					d_d.st = ST_PRE;
				end
			end
			ST_RBEAT: begin
				if (mem_in.rvalid) begin
					d_d.data_buf[q_q.beat] = mem_in.rdata;
					d_d.beat = q_q.beat + 1'b1;
					if (q_q.beat == LAST_BEAT) begin
						d_d.st = ST_PRE;
					end
				end
			end
			ST_PRE: begin
				d_d.mem.cmd  = ddc_pkg::CMD_PRE;
				d_d.mem.bank = q_q.bank;
				d_d.beat     = '0;
				if (q_q.write) begin
					d_d.axo[q_q.port].b_valid = 1'b1;
					d_d.st = ST_RESP;
				end else begin
					d_d.axo[q_q.port].r_valid = 1'b1;
					d_d.axo[q_q.port].r_data  = q_q.data_buf[0];
					d_d.axo[q_q.port].r_last  = 1'b0;
					d_d.st = ST_RSEND;
				end
			end
			ST_RSEND: begin
				if (port_edge[q_q.port] && axi_in[q_q.port].r_ready) begin
					d_d.beat = q_q.beat + 1'b1;
					d_d.axo[q_q.port].r_data = q_q.data_buf[d_d.beat];
					d_d.axo[q_q.port].r_last = (d_d.beat == LAST_BEAT);
					if (q_q.beat == LAST_BEAT) begin
						d_d.axo[q_q.port].r_valid = 1'b0;
						d_d.axo[q_q.port].r_last  = 1'b0;
						d_d.idle_cnt = '0;
						d_d.st = ST_IDLE;
					end
				end
			end
			ST_RESP: begin
				if (port_edge[q_q.port] && axi_in[q_q.port].b_ready) begin
					d_d.axo[q_q.port].b_valid = 1'b0;
					d_d.idle_cnt = '0;
					d_d.st = ST_IDLE;
				end
			end
			default: begin
				d_d.st = ST_INIT_WAIT;
			end
		endcase

		// Ready flags follow the next state so no handshake lands after a switch
		for (int p = 0; p < NP; p++) begin
			d_d.axo[p].a_ready = port_en[p] && (d_d.rr == p) && !take
				&& ((d_d.st == ST_IDLE) || (d_d.st == ST_PD) || (d_d.st == ST_SR));
			d_d.axo[p].w_ready = port_en[p] && (d_d.port == p) && (d_d.st == ST_WCOL)
				&& !(q_q.st == ST_WCOL && d_d.st != ST_WCOL);
		end

		// Fabric master reset restarts the sequencer; gate settings survive
		if ((cal_en || usr_en) && !master_rst_n) begin
			d_d             = '0;
			d_d.clk_prev    = eff_clk;
			d_d.scl_prev    = cal_scl;
			d_d.cal_coarse  = q_q.cal_coarse;
			d_d.cal_fine    = q_q.cal_fine;
			d_d.gate_coarse = q_q.gate_coarse;
			d_d.gate_fine   = q_q.gate_fine;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			q_q <= '0;
		end else begin
			q_q <= d_d;
		end
	end

	assign axi_out     = q_q.axo;
	assign mem_out     = q_q.mem;
	assign gate_coarse = q_q.gate_coarse;
	assign gate_fine   = q_q.gate_fine;
	assign init_done   = q_q.init_done;
	assign in_pd       = q_q.in_pd;
	assign in_sr       = q_q.in_sr;
endmodule

/* File: hw/ddc_pkg.sv */
// Constants and carrier types for the DDR controller front end
package ddc_pkg;
	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int NPORT     = 2;
	localparam int ADDR_W    = 32;
	localparam int DATA_W    = 32;
	localparam int COL_W     = 10;
	localparam int ROW_W     = 15;
	localparam int BANK_W    = 3;
	localparam int COLL_W    = 3;
	localparam int BYTE_LSB  = 2;
	localparam int BURST_LEN = 8;
	localparam int BEAT_W    = 3;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int WAKE_NS       = 24;
	localparam int WAKE_CYC      = (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WAKE_W        = 8;
	localparam int PD_IDLE_CYC   = 64;
	localparam int SR_IDLE_CYC   = 1024;
	localparam int IDLE_W        = 16;
	// ----------------------------------------
	// Gate delay and calibration
	// ----------------------------------------
	localparam int          COARSE_W   = 3;
	localparam int          FINE_W     = 8;
	localparam logic [2:0]  COARSE_MAX = 3'h5;
	localparam int          CAL_BITS   = 11;
	localparam int          CALCNT_W   = 4;
	// ----------------------------------------
	// Modes and commands
	// ----------------------------------------
	typedef enum logic [1:0] {MAP_BANK_ROW_COL, MAP_ROW_BANK_COL, MAP_ROW_COLH_BANK_COLL} ddc_map_type;
	typedef enum logic [1:0] {APD_OFF, APD_ACTIVE, APD_PRECHARGE} ddc_apd_type;
	typedef enum logic [1:0] {CTL_DISABLE, CTL_CAL, CTL_USER, CTL_BOTH} ddc_ctl_type;
	typedef enum logic [3:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREA,
		CMD_PDE_ACT, CMD_PDE_PRE, CMD_PDX, CMD_SRE, CMD_SRX} ddc_cmd_type;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic              a_valid;
		logic              a_write;
		logic [ADDR_W-1:0] a_addr;
		logic              w_valid;
		logic [DATA_W-1:0] w_data;
		logic              w_last;
		logic              b_ready;
		logic              r_ready;
	} ddc_axi_in_type;
	typedef struct packed {
		logic              a_ready;
		logic              w_ready;
		logic              b_valid;
		logic              r_valid;
		logic [DATA_W-1:0] r_data;
		logic              r_last;
	} ddc_axi_out_type;
	typedef struct packed {
		ddc_cmd_type       cmd;
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0]  row;
		logic [COL_W-1:0]  col;
		logic              wvalid;
		logic [DATA_W-1:0] wdata;
	} ddc_mem_out_type;
	typedef struct packed {
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
	} ddc_mem_in_type;
endpackage

/* File: bench/ddc_mem_model.sv */
// Behavioural memory that answers burst reads
`timescale 1ns/1ps
module ddc_mem_model #(
	parameter int LAT = 2
) (
	// Clock
	input	wire logic			sys_clk,
	// Command side
	input	wire ddc_pkg::ddc_mem_out_type	mem_out,
	output	ddc_pkg::ddc_mem_in_type	mem_in
);
	int	cnt = 99;
	initial mem_in = '0;
	always @(posedge sys_clk) begin
		#1;
		if (mem_out.cmd == ddc_pkg::CMD_RD)
			cnt = -LAT;
		else if (cnt < 99)
			cnt = cnt + 1;
		mem_in.rvalid = (cnt >= 0 && cnt < 8);
		// Idle bus shows inverted data so a stale read cannot pass
		mem_in.rdata = mem_in.rvalid ? 32'hC0DE_0000 + cnt : ~mem_in.rdata;
	end
endmodule

/* File: bench/ddc_ctrl_sva.sv */
// Port assertions for the DDR controller front end
`timescale 1ns/1ps
module ddc_ctrl_sva #(
	parameter int PD_IDLE = 64,
	parameter int SR_IDLE = 1024
) (
	// Clock and reset
	input	wire logic				sys_clk,
	input	wire logic				nrst,
	// Configuration and control
	input	wire ddc_pkg::ddc_apd_type		apd_mode,
	input	wire logic				sr_en,
	input	wire ddc_pkg::ddc_ctl_type		ctl_mode,
	input	wire logic				gate_ovr_en,
	input	wire logic [2:0]			gate_ovr_coarse,
	input	wire logic [7:0]			gate_ovr_fine,
	input	wire logic				master_rst_n,
	input	wire logic [1:0]			port_en,
	input	wire logic [1:0]			axi_clk,
	input	wire logic [1:0]			axi_clk_inv,
	// Outputs watched
	input	wire ddc_pkg::ddc_axi_out_type [1:0]	axi_out,
	input	wire ddc_pkg::ddc_mem_out_type		mem_out,
	input	wire logic [2:0]			gate_coarse,
	input	wire logic [7:0]			gate_fine,
	input	wire logic				init_done
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic [1:0]	pe;
	assign pe = axi_clk ^ axi_clk_inv;
	sequence s_beats8;
		mem_out.wvalid [*8] ##1 !mem_out.wvalid;
	endsequence
	sequence s_quiet;
		(mem_out.cmd != ddc_pkg::CMD_ACT) [*4];
	endsequence
	AST_BURST8: assert property ($rose(mem_out.wvalid) |-> s_beats8)
		else $error("write burst not eight beats");
	AST_COL_ALIGN: assert property (mem_out.cmd inside {ddc_pkg::CMD_RD, ddc_pkg::CMD_WR}
		|-> mem_out.col[2:0] == 3'h0) else $error("burst column not aligned");
	AST_WAKE: assert property (mem_out.cmd inside {ddc_pkg::CMD_PDX, ddc_pkg::CMD_SRX}
		|=> s_quiet) else $error("access too soon after wake");
	AST_APD_OFF: assert property (apd_mode == ddc_pkg::APD_OFF && $past(apd_mode) ==
		ddc_pkg::APD_OFF |-> !(mem_out.cmd inside {ddc_pkg::CMD_PDE_ACT, ddc_pkg::CMD_PDE_PRE}))
		else $error("power-down while off");
	AST_APD_KIND: assert property (mem_out.cmd == ddc_pkg::CMD_PDE_PRE |->
		$past(apd_mode) == ddc_pkg::APD_PRECHARGE) else $error("wrong power-down kind");
	AST_SR_OFF: assert property (!sr_en && !$past(sr_en) |->
		mem_out.cmd != ddc_pkg::CMD_SRE) else $error("self-refresh while disabled");
	AST_GATE_FINE: assert property (gate_ovr_en |=> gate_fine == $past(gate_ovr_fine))
		else $error("fine delay not overridden");
	AST_GATE_SAT: assert property (gate_ovr_en && gate_ovr_coarse > 3'h5 |=>
		gate_coarse == 3'h5) else $error("coarse delay not limited");
	AST_NO_CTL: assert property (ctl_mode == ddc_pkg::CTL_DISABLE && init_done |=>
		init_done) else $error("control pin acted while disabled");
	AST_FAB_RST: assert property (ctl_mode != ddc_pkg::CTL_DISABLE && !master_rst_n
		|=> !init_done) else $error("master reset ignored");
	AST_PORT_OFF: assert property (!port_en[1] && !$past(port_en[1]) |->
		!axi_out[1].a_ready) else $error("disabled port ready");
	AST_B_EDGE: assert property ($fell(axi_out[0].b_valid) |->
		$past(pe[0]) && !$past(pe[0], 2)) else $error("response off port edge");
	AST_R_LAST: assert property ($fell(axi_out[0].r_valid) |-> $past(axi_out[0].r_last))
		else $error("read ended without last");
endmodule
bind ddc_ctrl ddc_ctrl_sva #(.PD_IDLE(PD_IDLE), .SR_IDLE(SR_IDLE)) u_sva (
	.sys_clk(sys_clk), .nrst(nrst), .apd_mode(apd_mode), .sr_en(sr_en),
	.ctl_mode(ctl_mode), .gate_ovr_en(gate_ovr_en), .gate_ovr_coarse(gate_ovr_coarse),
	.gate_ovr_fine(gate_ovr_fine), .master_rst_n(master_rst_n), .port_en(port_en),
	.axi_clk(axi_clk), .axi_clk_inv(axi_clk_inv), .axi_out(axi_out), .mem_out(mem_out),
	.gate_coarse(gate_coarse), .gate_fine(gate_fine), .init_done(init_done));

/* File: bench/tb.sv */
// Self-checking bench for the DDR controller front end
`timescale 1ns/1ps
module tb;
	localparam int PDI = 8;
	localparam int SRI = 32;
	logic	sys_clk = 1'b0, nrst = 1'b0, sr_en = 1'b0, gate_ovr_en = 1'b0;
	logic	master_rst_n = 1'b1, seq_start = 1'b0, cal_scl = 1'b0, cal_sda = 1'b0;
	ddc_pkg::ddc_map_type	map_mode = ddc_pkg::MAP_BANK_ROW_COL;
	ddc_pkg::ddc_apd_type	apd_mode = ddc_pkg::APD_OFF;
	ddc_pkg::ddc_ctl_type	ctl_mode = ddc_pkg::CTL_CAL;
	logic [2:0]	gate_ovr_coarse = 3'h0, gate_coarse;
	logic [7:0]	gate_ovr_fine = 8'h00, gate_fine;
	logic [1:0]	port_en = 2'h1, axi_clk = 2'h0, axi_clk_inv = 2'h0, pe_q = 2'h0;
	wire [1:0]	pe = axi_clk ^ axi_clk_inv;
	wire [1:0]	edg = pe & ~pe_q;
	ddc_pkg::ddc_axi_in_type [1:0]	axi_in = '0;
	ddc_pkg::ddc_axi_out_type [1:0]	axi_out;
	ddc_pkg::ddc_axi_out_type	ao;
	ddc_pkg::ddc_mem_in_type	mem_in;
	ddc_pkg::ddc_mem_out_type	mem_out;
	logic		init_done, in_pd, in_sr;
	int		err_total = 0, comparisons = 0;
	int		cmd_cnt [16] = '{default: 0};
	logic [27:0]	got;
	logic [31:0]	wq [$];
	ddc_ctrl #(.PD_IDLE(PDI), .SR_IDLE(SRI)) dut (.sys_clk(sys_clk), .nrst(nrst),
		.map_mode(map_mode), .apd_mode(apd_mode), .sr_en(sr_en), .ctl_mode(ctl_mode),
		.gate_ovr_en(gate_ovr_en), .gate_ovr_coarse(gate_ovr_coarse),
		.gate_ovr_fine(gate_ovr_fine), .master_rst_n(master_rst_n), .seq_start(seq_start),
		.cal_scl(cal_scl), .cal_sda(cal_sda), .port_en(port_en), .axi_clk(axi_clk),
		.axi_clk_inv(axi_clk_inv), .axi_in(axi_in), .axi_out(axi_out), .mem_in(mem_in),
		.mem_out(mem_out), .gate_coarse(gate_coarse), .gate_fine(gate_fine),
		.init_done(init_done), .in_pd(in_pd), .in_sr(in_sr));
	ddc_mem_model u_mem (.sys_clk(sys_clk), .mem_out(mem_out), .mem_in(mem_in));
	// ----------------------------------------
	// Clocks and command monitor
	// ----------------------------------------
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		#1;
		pe_q = pe;
		axi_clk = ~axi_clk;
	end
	always @(posedge sys_clk) begin
		cmd_cnt[mem_out.cmd]++;
		if (mem_out.cmd == ddc_pkg::CMD_ACT) got[27:10] = {mem_out.bank, mem_out.row};
		if (mem_out.cmd inside {ddc_pkg::CMD_RD, ddc_pkg::CMD_WR}) got[9:0] = mem_out.col;
		if (mem_out.wvalid) wq.push_back(mem_out.wdata);
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task automatic clk(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Waits for a port edge with the chosen flag: 0 aready, 1 wready, 2 bvalid, 3 rvalid
	task automatic hs(input int p, input int k);
		int n;
		logic [3:0] v;
		n = 0;
		do begin
			@(posedge sys_clk);
			ao = axi_out[p];
			v = {ao.r_valid, ao.b_valid, ao.w_ready, ao.a_ready};
			n++;
		end while (!(edg[p] && v[k] === 1'b1) && n < 300);
		chk(n < 300, "handshake stalled");
		#1;
	endtask
	task automatic req(input int p, input logic w, input logic [31:0] a);
		axi_in[p].a_valid = 1'b1;
		axi_in[p].a_write = w;
		axi_in[p].a_addr = a;
		hs(p, 0);
		axi_in[p].a_valid = 1'b0;
	endtask
	task automatic rd(input int p, input logic [31:0] a);
		req(p, 1'b0, a);
		axi_in[p].r_ready = 1'b1;
		for (int b = 0; b < 8; b++) begin
			hs(p, 3);
			chk(ao.r_data === 32'hC0DE_0000 + b && ao.r_last === (b == 7), "read beat");
		end
		axi_in[p].r_ready = 1'b0;
	endtask
	task automatic wr(input logic [31:0] a);
		req(0, 1'b1, a);
		wq.delete();
		axi_in[0].w_valid = 1'b1;
		for (int b = 0; b < 8; b++) begin
			axi_in[0].w_data = 32'h5A00_0000 + b;
			axi_in[0].w_last = (b == 7);
			hs(0, 1);
		end
		axi_in[0].w_valid = 1'b0;
		axi_in[0].b_ready = 1'b1;
		hs(0, 2);
		axi_in[0].b_ready = 1'b0;
		chk(wq.size() == 8, "write beat count");
		for (int b = 0; b < 8; b++) chk(wq[b] === 32'h5A00_0000 + b, "write data");
	endtask
	function automatic logic [27:0] map_exp(input int m, input logic [31:0] a);
		logic [27:0] w;
		w = a[29:2];
		case (m)
			0: map_exp = {w[27:3], 3'h0};
			1: map_exp = {w[12:10], w[27:13], w[9:3], 3'h0};
			default: map_exp = {w[5:3], w[27:13], w[12:6], 3'h0};
		endcase
	endfunction
	task automatic shift(input logic [10:0] v);
		for (int i = 10; i >= 0; i--) begin
			cal_sda = v[i];
			clk(2);
			cal_scl = 1'b1;
			clk(2);
			cal_scl = 1'b0;
		end
		clk(3);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_gate();
		gate_ovr_en = 1'b1;
		gate_ovr_coarse = 3'h7;
		gate_ovr_fine = 8'hAB;
		clk(2);
		chk(gate_coarse === 3'h5 && gate_fine === 8'hAB, "gate limit");
		gate_ovr_coarse = 3'h3;
		gate_ovr_fine = 8'hFF;
		clk(2);
		chk(gate_coarse === 3'h3 && gate_fine === 8'hFF, "gate override");
		gate_ovr_en = 1'b0;
	endtask
	task automatic t_map();
		for (int m = 0; m < 3; m++) begin
			map_mode = ddc_pkg::ddc_map_type'(m);
			rd(0, 32'h6ABC_DE5C);
			chk(got === map_exp(m, 32'h6ABC_DE5C), "address split");
		end
	endtask
	task automatic t_port();
		axi_in[1].a_valid = 1'b1;
		repeat (30) begin
			@(posedge sys_clk);
			chk(axi_out[1].a_ready === 1'b0, "disabled port ready");
		end
		#1;
		axi_in[1].a_valid = 1'b0;
		port_en = 2'h3;
		axi_clk_inv[1] = 1'b1;
		rd(1, 32'h0000_1000);
		wr(32'h0000_2000);
	endtask
	task automatic t_pwr(input ddc_pkg::ddc_apd_type m, input ddc_pkg::ddc_cmd_type c);
		int pre;
		apd_mode = m;
		pre = cmd_cnt[c];
		clk(PDI + 6);
		chk(in_pd === 1'b1 && cmd_cnt[c] == pre + 1, "power-down entry");
		pre = cmd_cnt[ddc_pkg::CMD_PDX];
		rd(0, 32'h0000_0040);
		chk(cmd_cnt[ddc_pkg::CMD_PDX] == pre + 1 && in_pd === 1'b0, "wake");
	endtask
	task automatic t_sr();
		int pre;
		// Power-down comes first, so refresh entry also walks the power-down exit
		apd_mode = ddc_pkg::APD_ACTIVE;
		sr_en = 1'b1;
		pre = cmd_cnt[ddc_pkg::CMD_SRE];
		clk(SRI + 6);
		chk(in_sr === 1'b1 && cmd_cnt[ddc_pkg::CMD_SRE] == pre + 1, "refresh entry");
		chk(in_pd === 1'b0, "power-down left before refresh");
		pre = cmd_cnt[ddc_pkg::CMD_SRX];
		rd(0, 32'h0000_0080);
		chk(cmd_cnt[ddc_pkg::CMD_SRX] == pre + 1, "refresh exit");
		apd_mode = ddc_pkg::APD_OFF;
		sr_en = 1'b0;
		clk(SRI + 6);
		chk(in_sr === 1'b0 && in_pd === 1'b0, "idle entry while off");
	endtask
	task automatic t_ctl();
		shift({3'h2, 8'h5A});
		chk(gate_coarse === 3'h2 && gate_fine === 8'h5A, "calibrated gate");
		master_rst_n = 1'b0;
		clk(2);
		chk(init_done === 1'b0, "fabric reset");
		master_rst_n = 1'b1;
		clk(6);
		chk(init_done === 1'b1 && gate_fine === 8'h5A, "restart");
		ctl_mode = ddc_pkg::CTL_USER;
		master_rst_n = 1'b0;
		clk(2);
		master_rst_n = 1'b1;
		clk(10);
		chk(init_done === 1'b0, "sequencer wait");
		seq_start = 1'b1;
		clk(4);
		seq_start = 1'b0;
		chk(init_done === 1'b1, "sequencer start");
		ctl_mode = ddc_pkg::CTL_BOTH;
		shift({3'h1, 8'h3C});
		chk(gate_coarse === 3'h1 && gate_fine === 8'h3C, "both: calibrated gate");
		master_rst_n = 1'b0;
		clk(2);
		master_rst_n = 1'b1;
		clk(10);
		chk(init_done === 1'b0, "both: sequencer wait");
		seq_start = 1'b1;
		clk(4);
		seq_start = 1'b0;
		chk(init_done === 1'b1, "both: sequencer start");
		ctl_mode = ddc_pkg::CTL_DISABLE;
		master_rst_n = 1'b0;
		shift({3'h4, 8'h11});
		chk(init_done === 1'b1 && gate_fine === 8'h3C, "pins ignored");
		master_rst_n = 1'b1;
	endtask
	task automatic print_verdict();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		clk(4);
		chk(init_done === 1'b1, "init done");
		t_gate();
		t_map();
		t_port();
		t_pwr(ddc_pkg::APD_ACTIVE, ddc_pkg::CMD_PDE_ACT);
		t_pwr(ddc_pkg::APD_PRECHARGE, ddc_pkg::CMD_PDE_PRE);
		t_sr();
		t_ctl();
		print_verdict();
	end
	// Whole sequence needs about 650 cycles; allow ample margin
	initial begin
		#200us;
		err_total++;
		print_verdict();
	end
endmodule
